// [core/color_fw_pkg.sv]
// constants and types shared by the colour result and update register bank
`default_nettype none
package color_fw_pkg;
  // byte addresses of the register map
  localparam logic [7:0] UPRIME_CHROMA_RESULT_ADDR    = 8'h28;
  localparam logic [7:0] VPRIME_CHROMA_RESULT_ADDR    = 8'h2C;
  localparam logic [7:0] UCS_U_COORD_RESULT_ADDR      = 8'h30;
  localparam logic [7:0] UCS_V_COORD_RESULT_ADDR      = 8'h34;
  localparam logic [7:0] LOCUS_DISTANCE_RESULT_ADDR   = 8'h38;
  localparam logic [7:0] ILLUMINANCE_RESULT_HIGH_ADDR = 8'h3C;
  localparam logic [7:0] ILLUMINANCE_RESULT_LOW_ADDR  = 8'h3D;
  localparam logic [7:0] COLOR_TEMP_RESULT_HIGH_ADDR  = 8'h3E;
  localparam logic [7:0] COLOR_TEMP_RESULT_LOW_ADDR   = 8'h3F;
  localparam logic [7:0] CODE_UPDATE_CONTROL_ADDR     = 8'h48;
  localparam logic [7:0] IMAGE_PROGRESS_COUNT_HIGH_ADDR = 8'h49;
  localparam logic [7:0] IMAGE_PROGRESS_COUNT_LOW_ADDR  = 8'h4A;
  localparam logic [7:0] IMAGE_BYTE_PORT_ADDR         = 8'h4B;

  // bit positions inside the control byte
  localparam int CTRL_START_BIT    = 7;
  localparam int CTRL_ABORT_BIT    = 6;
  localparam int CTRL_COMPLETE_BIT = 5;
  localparam int CTRL_LOCK_BIT     = 4;
  localparam int CTRL_SWITCH_BIT   = 3;
  localparam int CTRL_FIRST_BIT    = 2;
  localparam int CTRL_ERROR_BIT    = 1;
  localparam int CTRL_VALID_BIT    = 0;

  // flash image slots and image length
  localparam logic [17:0] FIRST_SLOT_BASE  = 18'h12000;
  localparam logic [17:0] SECOND_SLOT_BASE = 18'h22000;
  localparam logic [15:0] IMAGE_LENGTH     = 16'hE000;

  // reset values
  localparam logic [15:0] PROGRESS_RESET   = 16'h0000;
  localparam logic [7:0]  PAYLOAD_RESET    = 8'h00;
  localparam logic        FIRST_ACTIVE_RESET = 1'b1;

  // payload buffer shape
  localparam int BUF_WIDTH = 26;
  localparam int BUF_DEPTH = 4;

  // update sequencer states
  typedef enum logic [1:0] {
    UPD_IDLE,
    UPD_LOADING,
    UPD_DONE
  } upd_state_t;

  // calibrated measurement results from the colour core
  typedef struct packed {
    logic [31:0] uprime;
    logic [31:0] vprime;
    logic [31:0] ucs_u;
    logic [31:0] ucs_v;
    logic [31:0] duv;
    logic [15:0] lux;
    logic [15:0] cct;
  } result_t;

  // one byte bound for flash
  typedef struct packed {
    logic [17:0] addr;
    logic [7:0]  data;
  } flash_byte_t;
endpackage
`default_nettype wire

// [core/color_result_and_fw_update_regs.sv]
// colour result registers and firmware update path with payload buffer
`timescale 1ns/10ps
`default_nettype none

// small first-in first-out buffer of flip-flops
module payload_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             flush_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push;
  wire              pop;

  // handshakes; the fill level is one bit wider than the pointers, so
  // full (DEPTH entries) and empty never share an encoding
  assign in_ready_out  = (count != (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // pointers and fill level; a flush empties the buffer in one edge and
  // wins over a push or pop in that cycle
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage write; entries are not reset, so the draining side must
  // only use out_data_out while out_valid_out is high
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end
endmodule

module color_result_and_fw_update_regs (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  // byte register port from the host interface
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  input  wire logic [7:0]                reg_wdata_in,
  output logic      [7:0]                reg_rdata_out,
  output logic                           reg_rdata_valid_out,
  // calibrated results from the colour core
  input  wire color_fw_pkg::result_t     results_in,
  input  wire logic                      results_valid_in,
  // checksum verdict on the inactive slot
  input  wire logic                      verify_ok_in,
  // byte stream towards the flash writer
  output logic                           flash_valid_out,
  input  wire logic                      flash_ready_in,
  output color_fw_pkg::flash_byte_t      flash_byte_out,
  // status towards the host side and boot logic
  output logic                           payload_ready_out,
  output logic                           boot_lock_out,
  output logic                           first_slot_active_out
);
  color_fw_pkg::result_t    results;
  color_fw_pkg::upd_state_t state;
  color_fw_pkg::upd_state_t next_state;
  logic [15:0]              progress;
  logic [7:0]               payload;
  logic                     fault;
  logic                     lock;
  logic                     first_active;
  logic                     other_valid;

  // byte selection from a big-endian word
  // byte 0 of a result is its most significant byte
  function automatic logic [7:0] word_byte(input logic [31:0] w,
                                           input logic [1:0] idx);
    word_byte = w[8*(3-idx) +: 8];
  endfunction

  // address window test for four-byte results
  // the two low address bits are ignored here, they pick the byte
  function automatic logic in_word(input logic [7:0] a,
                                   input logic [7:0] base);
    in_word = (a[7:2] == base[7:2]);
  endfunction

  // write decode; one address per cycle, so a control write and a
  // payload write can never fall in the same cycle
  wire ctrl_wr    = reg_wr_in
                  & (reg_addr_in == color_fw_pkg::CODE_UPDATE_CONTROL_ADDR);
  wire payload_wr = reg_wr_in
                  & (reg_addr_in == color_fw_pkg::IMAGE_BYTE_PORT_ADDR);
  wire abort_req  = ctrl_wr & reg_wdata_in[color_fw_pkg::CTRL_ABORT_BIT];
  wire start_req  = ctrl_wr & reg_wdata_in[color_fw_pkg::CTRL_START_BIT];
  wire switch_req = ctrl_wr & reg_wdata_in[color_fw_pkg::CTRL_SWITCH_BIT];

  // payload buffer hookup
  // a payload write that is not accepted is a refused byte and a fault
  wire                            fifo_in_ready;
  wire                            fifo_out_valid;
  wire color_fw_pkg::flash_byte_t fifo_out_data;
  wire                            out_slot_free = ~flash_valid_out
                                                | flash_ready_in;
  wire                            loading = (state == color_fw_pkg::UPD_LOADING);
  wire                            accept  = payload_wr & loading
                                          & fifo_in_ready & ~abort_req;
  wire                            bad_wr  = payload_wr & ~abort_req
                                          & ~(loading & fifo_in_ready);
  wire                            last_byte = accept
      & (progress == color_fw_pkg::IMAGE_LENGTH - 16'h0001);
  wire [17:0]                     slot_base = first_active
      ? color_fw_pkg::SECOND_SLOT_BASE
      : color_fw_pkg::FIRST_SLOT_BASE;
  // flash address is fixed as the byte is buffered; a later slot
  // toggle only moves bytes that are still to come
  wire color_fw_pkg::flash_byte_t fifo_in_data = '{
      addr: slot_base + {2'b00, progress},
      data: reg_wdata_in};

  payload_fifo #(
    .WIDTH (color_fw_pkg::BUF_WIDTH),
    .DEPTH (color_fw_pkg::BUF_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .flush_in      (abort_req),
    .in_valid_in   (accept),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (out_slot_free),
    .out_data_out  (fifo_out_data)
  );

  // update sequencer next state
  // start counts only from idle; a finished image needs an abort first
  always_comb
  begin
    next_state = state;
    case (state)
      color_fw_pkg::UPD_IDLE:
        if (start_req)
          next_state = color_fw_pkg::UPD_LOADING;
      color_fw_pkg::UPD_LOADING:
        if (last_byte)
          next_state = color_fw_pkg::UPD_DONE;
      color_fw_pkg::UPD_DONE:
        next_state = state;
      default:
        next_state = color_fw_pkg::UPD_IDLE;
    endcase
    if (abort_req)
      next_state = color_fw_pkg::UPD_IDLE;
  end

  // sequencer state and progress count
  // the count stops at the image length because loading ends there
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state    <= color_fw_pkg::UPD_IDLE;
      progress <= color_fw_pkg::PROGRESS_RESET;
    end
    else
    begin
      state <= next_state;
      if (abort_req)
        progress <= color_fw_pkg::PROGRESS_RESET;
      else if (accept)
        progress <= progress + 16'h0001;
    end
  end

  // payload byte and fault flag
  // the byte port keeps the last byte written, even a refused one
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      payload <= color_fw_pkg::PAYLOAD_RESET;
      fault   <= 1'b0;
    end
    else
    begin
      if (payload_wr)
        payload <= reg_wdata_in;
      fault <= (fault & ~abort_req) | bad_wr;
    end
  end

  // slot selection, lock and checksum verdict
  // lock follows bit 4 of every control write, so a plain start clears it
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      first_active <= color_fw_pkg::FIRST_ACTIVE_RESET;
      lock         <= 1'b0;
      other_valid  <= 1'b0;
    end
    else
    begin
      if (switch_req)
        first_active <= ~first_active;
      if (ctrl_wr)
        lock <= reg_wdata_in[color_fw_pkg::CTRL_LOCK_BIT];
      other_valid <= verify_ok_in;
    end
  end

  // captured measurement results
  // no snapshot: a multi-byte read may mix two result updates
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      results <= '0;
    else if (results_valid_in)
      results <= results_in;
  end

  // flash output stage; it holds while the writer stalls, and its byte
  // only reloads with a real entry so unwritten storage never shows
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || abort_req)
    begin
      flash_valid_out <= 1'b0;
      flash_byte_out  <= '0;
    end
    else if (out_slot_free)
    begin
      flash_valid_out <= fifo_out_valid;
      if (fifo_out_valid)
        flash_byte_out <= fifo_out_data;
    end
  end

  // status outputs; payload ready lags the buffer by one cycle, so a
  // host that may fill the buffer leaves a cycle between bytes
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      payload_ready_out     <= 1'b0;
      boot_lock_out         <= 1'b0;
      first_slot_active_out <= color_fw_pkg::FIRST_ACTIVE_RESET;
    end
    else
    begin
      payload_ready_out     <= loading & fifo_in_ready;
      boot_lock_out         <= lock;
      first_slot_active_out <= first_active;
    end
  end

  // control byte as read back; write-only bits always read as zero
  function automatic logic [7:0] ctrl_byte(input logic busy,
                                           input logic done,
                                           input logic lk,
                                           input logic first,
                                           input logic err,
                                           input logic ok);
    ctrl_byte                                  = 8'h00;
    ctrl_byte[color_fw_pkg::CTRL_START_BIT]    = busy;
    ctrl_byte[color_fw_pkg::CTRL_COMPLETE_BIT] = done;
    ctrl_byte[color_fw_pkg::CTRL_LOCK_BIT]     = lk;
    ctrl_byte[color_fw_pkg::CTRL_FIRST_BIT]    = first;
    ctrl_byte[color_fw_pkg::CTRL_ERROR_BIT]    = err;
    ctrl_byte[color_fw_pkg::CTRL_VALID_BIT]    = ok;
  endfunction

  wire [7:0] ctrl_view = ctrl_byte(state != color_fw_pkg::UPD_IDLE,
                                   state == color_fw_pkg::UPD_DONE,
                                   lock, first_active, fault, other_valid);

  // read data selection
  // unmapped addresses read as zero
  wire [1:0] bsel = reg_addr_in[1:0];
  wire [7:0] rd_sel =
    in_word(reg_addr_in, color_fw_pkg::UPRIME_CHROMA_RESULT_ADDR)
      ? word_byte(results.uprime, bsel) :
    in_word(reg_addr_in, color_fw_pkg::VPRIME_CHROMA_RESULT_ADDR)
      ? word_byte(results.vprime, bsel) :
    in_word(reg_addr_in, color_fw_pkg::UCS_U_COORD_RESULT_ADDR)
      ? word_byte(results.ucs_u, bsel) :
    in_word(reg_addr_in, color_fw_pkg::UCS_V_COORD_RESULT_ADDR)
      ? word_byte(results.ucs_v, bsel) :
    in_word(reg_addr_in, color_fw_pkg::LOCUS_DISTANCE_RESULT_ADDR)
      ? word_byte(results.duv, bsel) :
    (reg_addr_in == color_fw_pkg::ILLUMINANCE_RESULT_HIGH_ADDR)
      ? results.lux[15:8] :
    (reg_addr_in == color_fw_pkg::ILLUMINANCE_RESULT_LOW_ADDR)
      ? results.lux[7:0] :
    (reg_addr_in == color_fw_pkg::COLOR_TEMP_RESULT_HIGH_ADDR)
      ? results.cct[15:8] :
    (reg_addr_in == color_fw_pkg::COLOR_TEMP_RESULT_LOW_ADDR)
      ? results.cct[7:0] :
    (reg_addr_in == color_fw_pkg::CODE_UPDATE_CONTROL_ADDR)
      ? ctrl_view :
    (reg_addr_in == color_fw_pkg::IMAGE_PROGRESS_COUNT_HIGH_ADDR)
      ? progress[15:8] :
    (reg_addr_in == color_fw_pkg::IMAGE_PROGRESS_COUNT_LOW_ADDR)
      ? progress[7:0] :
    (reg_addr_in == color_fw_pkg::IMAGE_BYTE_PORT_ADDR)
      ? payload : 8'h00;

  // registered read answer, one cycle after the strobe
  // read data holds until the next read strobe
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out       <= 8'h00;
      reg_rdata_valid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_valid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= rd_sel;
    end
  end
endmodule
`default_nettype wire

// [core/placeholder_none.sv]
// intentionally empty design unit list
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [bench/flash_sink.sv]
// flash writer model that takes bytes from the update stream
`timescale 1ns/10ps
`default_nettype none
module flash_sink (
  // clock and stream
  input  wire logic                      clk_in,
  input  wire logic                      valid_in,
  input  wire color_fw_pkg::flash_byte_t byte_in,
  input  wire logic                      slow_in,
  output logic                           ready_out
);
  int          n_taken   = 0;
  logic [17:0] last_addr = 18'h00000;
  logic [7:0]  last_data = 8'h00;
  logic        stall     = 1'b0;
  // slow mode refuses every other cycle
  assign ready_out = !slow_in || stall;
  // take a byte on valid and ready
  always @(posedge clk_in)
  begin
    stall <= slow_in && !stall;
    if (valid_in && ready_out)
    begin
      n_taken   <= n_taken + 1;
      last_addr <= byte_in.addr;
      last_data <= byte_in.data;
    end
  end
endmodule
`default_nettype wire

// [bench/regs_monitor.sv]
// concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module regs_monitor (
  // clock, reset and register port
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic [7:0]                reg_rdata_out,
  input  wire logic                      reg_rdata_valid_out,
  // flash stream and status
  input  wire logic                      flash_valid_out,
  input  wire logic                      flash_ready_in,
  input  wire color_fw_pkg::flash_byte_t flash_byte_out,
  input  wire logic                      payload_ready_out,
  input  wire logic                      boot_lock_out,
  input  wire logic                      first_slot_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic        ctl_wr;
  logic [17:0] fa;
  // control byte write decode and stream address
  assign ctl_wr = reg_wr_in && reg_addr_in == 8'h48;
  assign fa = flash_byte_out.addr;
  sequence abort_s;
    ctl_wr && reg_wdata_in[6];
  endsequence
  sequence flush_s;
    !flash_valid_out ##1 !payload_ready_out;
  endsequence
  property lock_p;
    logic v;
    (ctl_wr, v = reg_wdata_in[4]) ##1 !reg_wr_in |-> ##1 boot_lock_out == v;
  endproperty
  property toggle_p;
    logic v;
    ctl_wr && reg_wdata_in[3] ##1 (!reg_wr_in, v = first_slot_active_out)
      |-> ##1 first_slot_active_out != v;
  endproperty
  read_answer_a: assert property (reg_rd_in |=> reg_rdata_valid_out)
    else $error("read not answered next cycle");
  read_quiet_a: assert property (!reg_rd_in |=> !reg_rdata_valid_out)
    else $error("read valid without a read");
  unmapped_zero_a: assert property (
    reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  abort_flush_a: assert property (abort_s |=> flush_s)
    else $error("abort left the stream busy");
  lock_copy_a: assert property (lock_p)
    else $error("boot lock does not follow control write");
  slot_toggle_a: assert property (toggle_p)
    else $error("slot did not toggle");
  stream_hold_a: assert property (
    flash_valid_out && !flash_ready_in && !(ctl_wr && reg_wdata_in[6])
      |=> flash_valid_out && $stable(flash_byte_out))
    else $error("flash byte changed while stalled");
  slot_range_a: assert property (flash_valid_out |->
    (fa >= 18'h12000 && fa < 18'h20000) || (fa >= 18'h22000 && fa < 18'h30000))
    else $error("flash address outside both slots");
endmodule
bind color_result_and_fw_update_regs regs_monitor u_regs_monitor (
  .clk_in, .nrst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
  .reg_rdata_out, .reg_rdata_valid_out, .flash_valid_out, .flash_ready_in,
  .flash_byte_out, .payload_ready_out, .boot_lock_out, .first_slot_active_out);
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the colour result and update register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                      clk_in           = 1'b0;
  logic                      nrst_in          = 1'b0;
  logic [7:0]                reg_addr_in      = 8'h00;
  logic                      reg_wr_in        = 1'b0;
  logic                      reg_rd_in        = 1'b0;
  logic [7:0]                reg_wdata_in     = 8'h00;
  color_fw_pkg::result_t     results_in       = '0;
  logic                      results_valid_in = 1'b0;
  logic                      verify_ok_in     = 1'b0;
  logic                      slow             = 1'b0;
  logic [7:0]                reg_rdata_out;
  logic                      reg_rdata_valid_out;
  logic                      flash_valid_out;
  logic                      flash_ready_in;
  color_fw_pkg::flash_byte_t flash_byte_out;
  logic                      payload_ready_out;
  logic                      boot_lock_out;
  logic                      first_slot_active_out;
  logic [191:0]              res = {32'h3F4A1B2C, 32'hBE112233, 32'h44556677,
                                    32'h8899AABB, 32'hCCDDEEF0, 16'h03E8, 16'h0BB8};
  int                        n_errors = 0;
  int                        samples_checked = 0;
  int                        cycles = 0;
  int                        taken = 0;

  color_result_and_fw_update_regs u_color_result_and_fw_update_regs (
    .clk_in, .nrst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .reg_rdata_out, .reg_rdata_valid_out, .results_in, .results_valid_in,
    .verify_ok_in, .flash_valid_out, .flash_ready_in, .flash_byte_out,
    .payload_ready_out, .boot_lock_out, .first_slot_active_out);
  flash_sink u_flash_sink (.clk_in, .valid_in(flash_valid_out),
    .byte_in(flash_byte_out), .slow_in(slow), .ready_out(flash_ready_in));

  // 200 MHz clock and cycle ceiling; the tests need about 58k cycles
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > 70000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one register write, strobe lowered a cycle before the next access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clk_in);
    #1 reg_wr_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  // one register read compared under a mask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge clk_in);
    #1 reg_rd_in = 1'b0;
    check({31'h0, reg_rdata_valid_out}, 32'h1);
    check({24'h0, reg_rdata_out & m}, {24'h0, e});
    @(posedge clk_in);
    #1;
  endtask
  // payload bytes only when the port is ready; back to back to a fast
  // sink, with a gap to a slow one so the lagging ready flag settles
  task automatic stream(input int from, input int upto);
    int k;
    k = from;
    while (k < upto)
    begin
      reg_wr_in = payload_ready_out === 1'b1;
      reg_addr_in = 8'h4B;
      reg_wdata_in = k[7:0] ^ 8'h5A;
      if (payload_ready_out === 1'b1)
        k++;
      @(posedge clk_in);
      #1;
      if (slow || k >= upto)
      begin
        reg_wr_in = 1'b0;
        @(posedge clk_in);
        #1;
      end
    end
  endtask
  task automatic wait_taken(input int n);
    int i;
    i = 0;
    while (i < 400 && u_flash_sink.n_taken < n)
    begin
      @(posedge clk_in);
      #1 i++;
    end
    check(u_flash_sink.n_taken, n);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    rd(8'h49, 8'h00);
    rd(8'h4A, 8'h00);
    rd(8'h4B, 8'h00);
    rd(8'h48, 8'h04);
    check({boot_lock_out, first_slot_active_out}, 32'h1);
    $display("test reset done");
    results_in = res;
    results_valid_in = 1'b1;
    @(posedge clk_in);
    #1 results_valid_in = 1'b0;
    wr(8'h28, 8'hFF);
    for (int a = 40; a < 64; a++)
      rd(a[7:0], res[8*(63-a) +: 8]);
    rd(8'h00, 8'h00);
    rd(8'h40, 8'h00);
    $display("test results done");
    verify_ok_in = 1'b1;
    @(posedge clk_in);
    #1 rd(8'h48, 8'h05);
    verify_ok_in = 1'b0;
    wr(8'h4B, 8'hA5);
    rd(8'h4B, 8'hA5);
    rd(8'h48, 8'h06);
    wr(8'h48, 8'h40);
    rd(8'h48, 8'h04);
    $display("test fault done");
    wr(8'h48, 8'h80);
    rd(8'h48, 8'h84);
    slow = 1'b1;
    stream(0, 8);
    wait_taken(8);
    check(u_flash_sink.last_addr, 32'h22007);
    check(u_flash_sink.last_data, 32'h5D);
    rd(8'h4A, 8'h08);
    slow = 1'b0;
    stream(8, 57344);
    wait_taken(57344);
    check(u_flash_sink.last_addr, 32'h2FFFF);
    rd(8'h48, 8'h20, 8'h22);
    rd(8'h49, 8'hE0);
    rd(8'h4A, 8'h00);
    wr(8'h4B, 8'h11);
    rd(8'h48, 8'h02, 8'h02);
    wr(8'h48, 8'h40);
    rd(8'h49, 8'h00);
    $display("test update done");
    wr(8'h48, 8'h18);
    rd(8'h48, 8'h10, 8'h14);
    check({boot_lock_out, first_slot_active_out}, 32'h2);
    wr(8'h48, 8'h80);
    stream(0, 1);
    wait_taken(57345);
    check(u_flash_sink.last_addr, 32'h12000);
    check(boot_lock_out, 32'h0);
    $display("test slots done");
    slow = 1'b1;
    stream(1, 5);
    wr(8'h48, 8'h40);
    rd(8'h4A, 8'h00);
    rd(8'h48, 8'h00);
    taken = u_flash_sink.n_taken;
    repeat (20) @(posedge clk_in);
    #1 check(u_flash_sink.n_taken, taken);
    check(payload_ready_out, 32'h0);
    $display("test abort done");
    complete_run();
  end
endmodule
`default_nettype wire
